// ===== hdl/prc_core.sv
// Scan reconfiguration controller: parameter cache, scan shifter and PLL reset sequencing
`timescale 1ns/1ps
module prc_core (
    // Parameter clock and reset
    input wire logic clock,
    input wire logic srst,
    // Scan link clock
    input wire logic scan_clock,
    // User side
    input wire logic write_param,
    input wire logic reconfig,
    input wire logic [prc_pkg::TYPE_W-1:0] counter_type,
    input wire logic [prc_pkg::PARAM_W-1:0] counter_param,
    input wire logic [prc_pkg::DATA_W-1:0] data_in,
    input wire logic pll_areset_in,
    output logic busy,
    output logic prior_parity,
    // PLL side
    input wire logic pll_scandone,
    input wire logic pll_scandataout,
    output logic pll_scanclkena,
    output logic pll_scandata,
    output logic pll_configupdate,
    output logic pll_areset
);
    prc_pkg::prc_state_t state;
    logic [prc_pkg::CHAIN_LEN-1:0] cache;
    logic [prc_pkg::TYPE_W-1:0] lat_type;
    logic [prc_pkg::PARAM_W-1:0] lat_param;
    logic [prc_pkg::DATA_W-1:0] lat_data;
    logic [3:0] ar_cnt;
    logic go_tgl;
    logic done_meta, done_s, done_d;
    logic sd_meta, sd_s;
    logic link_done;
    logic [4:0] lk_hold;
    logic lk_rst_req;
    // Link domain
    logic rst_meta, lk_rst;
    logic go_meta, go_s, go_d;
    prc_pkg::prc_link_t lk_state;
    logic [prc_pkg::CNT_W-1:0] lk_cnt;
    logic done_tgl;
    logic lk_parity;
    logic [prc_pkg::CNT_W-1:0] ena_len;

    // Busy is any non-idle state, so it follows the strobe by one edge
    assign busy = (state != prc_pkg::PRC_IDLE);
    assign link_done = done_s ^ done_d;

    // Sequencer; strobes are only looked at while idle
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= prc_pkg::PRC_IDLE;
        end else begin
            case (state)
                prc_pkg::PRC_IDLE: begin
                    if (write_param) begin
                        state <= prc_pkg::PRC_WRITE;
                    end else if (reconfig) begin
                        state <= prc_pkg::PRC_SHIFT;
                    end
                end
                prc_pkg::PRC_WRITE: state <= prc_pkg::PRC_IDLE;
                prc_pkg::PRC_SHIFT: begin
                    if (link_done) begin
                        state <= prc_pkg::PRC_WAIT_DONE;
                    end
                end
                prc_pkg::PRC_WAIT_DONE: begin
                    if (sd_s) begin
                        state <= prc_pkg::PRC_ARESET;
                    end
                end
                prc_pkg::PRC_ARESET: begin
                    if (ar_cnt == 4'h0) begin
                        state <= prc_pkg::PRC_IDLE;
                    end
                end
                default: state <= prc_pkg::PRC_IDLE;
            endcase
        end
    end

    // Capture selects and data only when a write is accepted
    always_ff @(posedge clock) begin
        if (srst) begin
            lat_type <= 4'h0;
            lat_param <= 3'h0;
            lat_data <= 9'h000;
        end else if (state == prc_pkg::PRC_IDLE && write_param) begin
            lat_type <= counter_type;
            lat_param <= counter_param;
            lat_data <= data_in;
        end
    end

    // Cache write: only the low bits that fit the field are taken
    always_ff @(posedge clock) begin
        if (srst) begin
            cache <= '0;
        end else if (state == prc_pkg::PRC_WRITE && prc_pkg::field_legal(lat_type, lat_param)) begin
            for (int k = 0; k < prc_pkg::W_COUNT; k++) begin
                if (k < prc_pkg::field_width(lat_param)) begin
                    cache[prc_pkg::field_base(lat_type, lat_param) + k] <= lat_data[k];
                end
            end
        end
    end

    // Start request to the link side as a toggle
    always_ff @(posedge clock) begin
        if (srst) begin
            go_tgl <= 1'b0;
        end else if (state == prc_pkg::PRC_IDLE && !write_param && reconfig) begin
            go_tgl <= ~go_tgl;
        end
    end

    // Synchronisers for the link's done toggle and the PLL scan-done pin
    always_ff @(posedge clock) begin
        if (srst) begin
            done_meta <= 1'b0;
            done_s <= 1'b0;
            done_d <= 1'b0;
            sd_meta <= 1'b0;
            sd_s <= 1'b0;
        end else begin
            done_meta <= done_tgl;
            done_s <= done_meta;
            done_d <= done_s;
            sd_meta <= pll_scandone;
            sd_s <= sd_meta;
        end
    end

    // Scan output parity is steady once done toggles, so it is safe to take here
    always_ff @(posedge clock) begin
        if (srst) begin
            prior_parity <= 1'b0;
        end else if (state == prc_pkg::PRC_SHIFT && link_done) begin
            prior_parity <= lk_parity;
        end
    end

    // PLL reset: request input, or a fixed pulse after scan-done
    always_ff @(posedge clock) begin
        if (srst) begin
            pll_areset <= 1'b0;
            ar_cnt <= 4'h0;
        end else begin
            pll_areset <= pll_areset_in
                || (state == prc_pkg::PRC_WAIT_DONE && sd_s)
                || (state == prc_pkg::PRC_ARESET && ar_cnt != 4'h0);
            if (state == prc_pkg::PRC_WAIT_DONE) begin
                ar_cnt <= prc_pkg::ARESET_LAST;
            end else if (ar_cnt != 4'h0) begin
                ar_cnt <= ar_cnt - 4'h1;
            end
        end
    end

    // Stretch srst so the slower link clock is sure to see it; a short srst
    // would otherwise leave the shifter unreset and the link outputs unknown
    always_ff @(posedge clock) begin
        if (srst) begin
            lk_hold <= prc_pkg::LINK_RST_CYC;
            lk_rst_req <= 1'b1;
        end else begin
            if (lk_hold != 5'h00) begin
                lk_hold <= lk_hold - 5'h01;
            end
            lk_rst_req <= (lk_hold != 5'h00);
        end
    end

    // Link domain reset, the stretched request through two flops
    always_ff @(posedge scan_clock) begin
        rst_meta <= lk_rst_req;
        lk_rst <= rst_meta;
    end

    // Start toggle into the link domain
    always_ff @(posedge scan_clock) begin
        if (lk_rst) begin
            go_meta <= 1'b0;
            go_s <= 1'b0;
            go_d <= 1'b0;
        end else begin
            go_meta <= go_tgl;
            go_s <= go_meta;
            go_d <= go_s;
        end
    end

    // Shifter; the cache is frozen while busy, so reading it here is quasi-static
    always_ff @(posedge scan_clock) begin
        if (lk_rst) begin
            lk_state <= prc_pkg::PRC_LK_IDLE;
            lk_cnt <= 8'h00;
            pll_scanclkena <= 1'b0;
            pll_scandata <= 1'b0;
            pll_configupdate <= 1'b0;
            done_tgl <= 1'b0;
        end else begin
            case (lk_state)
                prc_pkg::PRC_LK_IDLE: begin
                    if (go_s ^ go_d) begin
                        lk_state <= prc_pkg::PRC_LK_SHIFT;
                        lk_cnt <= 8'(prc_pkg::CHAIN_LEN - 1);
                        pll_scanclkena <= 1'b1;
                        pll_scandata <= cache[prc_pkg::CHAIN_LEN-1];
                    end
                end
                prc_pkg::PRC_LK_SHIFT: begin
                    if (lk_cnt == 8'h00) begin
                        lk_state <= prc_pkg::PRC_LK_UPDATE;
                        pll_scanclkena <= 1'b0;
                        pll_configupdate <= 1'b1;
                    end else begin
                        lk_cnt <= lk_cnt - 8'h01;
                        pll_scandata <= cache[lk_cnt - 8'h01];
                    end
                end
                prc_pkg::PRC_LK_UPDATE: begin
                    pll_configupdate <= 1'b0;
                    done_tgl <= ~done_tgl;
                    lk_state <= prc_pkg::PRC_LK_IDLE;
                end
                default: lk_state <= prc_pkg::PRC_LK_IDLE;
            endcase
        end
    end

    // Parity of what the PLL shifts back, a cheap check of the old setting;
    // restarts each frame with the old top bit, seen before the first shift
    always_ff @(posedge scan_clock) begin
        if (lk_rst) begin
            lk_parity <= 1'b0;
        end else if (lk_state == prc_pkg::PRC_LK_IDLE && (go_s ^ go_d)) begin
            lk_parity <= pll_scandataout;
        end else if (lk_state == prc_pkg::PRC_LK_SHIFT && lk_cnt != 8'h00) begin
            lk_parity <= lk_parity ^ pll_scandataout;
        end
    end

    // Helper: length of the scan enable window
    always_ff @(posedge scan_clock) begin
        if (lk_rst || !pll_scanclkena) begin
            ena_len <= 8'h00;
        end else begin
            ena_len <= ena_len + 8'h01;
        end
    end

    a_write_busy: assert property (@(posedge clock) disable iff (srst)
        (state == prc_pkg::PRC_IDLE && write_param) |-> !busy ##1 busy)
        else $error("busy not raised after write strobe");
    a_cfg_busy: assert property (@(posedge clock) disable iff (srst)
        (state == prc_pkg::PRC_IDLE && !write_param && reconfig) |-> !busy ##1 busy[*3])
        else $error("busy not held after reconfigure strobe");
    a_cache_field: assert property (@(posedge clock) disable iff (srst)
        (state == prc_pkg::PRC_WRITE && lat_type == 4'h4 && lat_param == prc_pkg::PRM_BYPASS)
        |=> cache[4 * prc_pkg::FIELDS_W + prc_pkg::OFF_BYPASS] == $past(lat_data[0]))
        else $error("cache field not written");
    a_cache_hold: assert property (@(posedge clock) disable iff (srst)
        (state != prc_pkg::PRC_WRITE) |=> $stable(cache))
        else $error("cache changed outside a write");
    a_data_ignored: assert property (@(posedge clock) disable iff (srst)
        busy |=> $stable(lat_data))
        else $error("data taken while busy");
    a_areset_done: assert property (@(posedge clock) disable iff (srst)
        (state == prc_pkg::PRC_WAIT_DONE && sd_s) |=> pll_areset && busy)
        else $error("pll reset missing after scan done");
    a_areset_req: assert property (@(posedge clock) disable iff (srst)
        pll_areset_in |=> pll_areset)
        else $error("pll reset request ignored");
    a_busy_reset: assert property (@(posedge clock) disable iff (srst)
        $fell(busy) && $past(state) == prc_pkg::PRC_ARESET |-> $past(pll_areset, 2))
        else $error("busy fell before pll reset pulse");
    a_update_last: assert property (@(posedge scan_clock) disable iff (lk_rst)
        (lk_state == prc_pkg::PRC_LK_SHIFT && lk_cnt == 8'h00)
        |=> pll_configupdate && !pll_scanclkena ##1 !pll_configupdate)
        else $error("config update not after last bit");
    a_shift_len: assert property (@(posedge scan_clock) disable iff (lk_rst)
        $fell(pll_scanclkena) |-> $past(ena_len) == 8'(prc_pkg::CHAIN_LEN - 1))
        else $error("scan window has wrong length");
endmodule : prc_core

// ===== shared/prc_pkg.sv
// Shared constants, field layout and state encodings for the scan reconfiguration controller
package prc_pkg;
    // Port widths
    localparam int DATA_W = 9;
    localparam int TYPE_W = 4;
    localparam int PARAM_W = 3;
    // Counter types 0..8 are legal; each one holds the same four fields
    localparam logic [3:0] TYPE_LAST = 4'h8;
    localparam int FIELDS_W = 18;
    localparam int NUM_TYPES = 9;
    localparam int CHAIN_LEN = NUM_TYPES * FIELDS_W;
    localparam int CNT_W = 8;
    // Parameter codes and their bit offset inside a counter block
    localparam logic [2:0] PRM_HIGH = 3'h0;
    localparam logic [2:0] PRM_LOW = 3'h1;
    localparam logic [2:0] PRM_BYPASS = 3'h4;
    localparam logic [2:0] PRM_MODE = 3'h5;
    localparam int OFF_HIGH = 0;
    localparam int OFF_LOW = 8;
    localparam int OFF_BYPASS = 16;
    localparam int OFF_MODE = 17;
    localparam int W_COUNT = 8;
    localparam int W_FLAG = 1;
    // PLL reset pulse after scan-done
    localparam int CLK_MHZ = 100;
    localparam int ARESET_NS = 20;
    localparam int ARESET_CYC = (ARESET_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] ARESET_LAST = 4'(ARESET_CYC - 1);
    // Parameter clocks that the link reset is stretched over, three link periods in the bench
    localparam logic [4:0] LINK_RST_CYC = 5'h18;

    // Core sequencer, Gray coded along write and reconfigure paths
    typedef enum logic [2:0] {
        PRC_IDLE = 3'h0,
        PRC_SHIFT = 3'h1,
        PRC_WAIT_DONE = 3'h3,
        PRC_ARESET = 3'h2,
        PRC_WRITE = 3'h4
    } prc_state_t;

    // Link-side shifter states
    typedef enum logic [1:0] {
        PRC_LK_IDLE = 2'h0,
        PRC_LK_SHIFT = 2'h1,
        PRC_LK_UPDATE = 2'h3
    } prc_link_t;

    // Width of a parameter field, zero for an unknown code
    function automatic int field_width(input logic [2:0] prm);
        case (prm)
            PRM_HIGH, PRM_LOW: field_width = W_COUNT;
            PRM_BYPASS, PRM_MODE: field_width = W_FLAG;
            default: field_width = 0;
        endcase
    endfunction : field_width

    // First chain bit of a field
    function automatic int field_base(input logic [3:0] typ, input logic [2:0] prm);
        int off;
        case (prm)
            PRM_LOW: off = OFF_LOW;
            PRM_BYPASS: off = OFF_BYPASS;
            PRM_MODE: off = OFF_MODE;
            default: off = OFF_HIGH;
        endcase
        field_base = int'(typ) * FIELDS_W + off;
    endfunction : field_base

    // Selects that name a real cache field
    function automatic logic field_legal(input logic [3:0] typ, input logic [2:0] prm);
        field_legal = (typ <= TYPE_LAST) && (field_width(prm) != 0);
    endfunction : field_legal
endpackage : prc_pkg

// ===== sim/prc_core_tb.sv
// Random and corner stimulus for the scan reconfiguration controller
`timescale 1ns/1ps
module prc_core_tb;
    logic clock = 1'b0;
    logic scan_clock = 1'b0;
    logic srst = 1'b1;
    logic write_param = 1'b0;
    logic reconfig = 1'b0;
    logic [3:0] counter_type = 4'h0;
    logic [2:0] counter_param = 3'h0;
    logic [8:0] data_in = 9'h000;
    logic pll_areset_in = 1'b0;
    logic [7:0] done_dly = 8'h00;
    logic busy, prior_parity, pll_scandone, pll_scandataout;
    logic pll_scanclkena, pll_scandata, pll_configupdate, pll_areset;
    logic [161:0] latch, exp, old;
    logic [2:0] pk [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
    int last_bits, updates;
    int errors = 0;
    int checked = 0;
    // Parameter clock, and a link clock offset so edges never coincide
    always #5 clock = ~clock;
    initial begin
        #3;
        forever #40 scan_clock = ~scan_clock;
    end
    prc_core i_prc_core (.clock(clock), .srst(srst), .scan_clock(scan_clock),
        .write_param(write_param), .reconfig(reconfig), .counter_type(counter_type),
        .counter_param(counter_param), .data_in(data_in), .pll_areset_in(pll_areset_in),
        .busy(busy), .prior_parity(prior_parity), .pll_scandone(pll_scandone),
        .pll_scandataout(pll_scandataout), .pll_scanclkena(pll_scanclkena),
        .pll_scandata(pll_scandata), .pll_configupdate(pll_configupdate),
        .pll_areset(pll_areset));
    prc_pll_model i_prc_pll_model (.scan_clock(scan_clock), .scanclkena(pll_scanclkena),
        .scandata(pll_scandata), .configupdate(pll_configupdate), .areset(pll_areset),
        .done_dly(done_dly), .scandataout(pll_scandataout), .scandone(pll_scandone),
        .latch(latch), .last_bits(last_bits), .updates(updates));
    task automatic check(input logic [161:0] seen, input logic [161:0] want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, want);
        end
    endtask : check
    // Field offset and width inside a counter block
    function automatic int offs(input logic [2:0] p);
        offs = (p == 3'h1) ? 8 : (p == 3'h4) ? 16 : (p == 3'h5) ? 17 : 0;
    endfunction : offs
    function automatic int wid(input logic [2:0] p);
        wid = (p < 3'h2) ? 8 : (p == 3'h4 || p == 3'h5) ? 1 : 0;
    endfunction : wid
    // One cache write; data changes while busy, hold re-strobes in the busy cycle
    task automatic wr(input logic [3:0] t, input logic [2:0] p, input logic [8:0] d,
        input bit hold);
        @(posedge clock);
        write_param <= 1'b1;
        counter_type <= t;
        counter_param <= p;
        data_in <= d;
        #1 check(busy, 1'b0);
        @(posedge clock);
        write_param <= hold;
        data_in <= ~d;
        #1 check(busy, 1'b1);
        @(posedge clock);
        write_param <= 1'b0;
        #1 check(busy, 1'b0);
        if (t <= 4'h8) begin
            for (int k = 0; k < wid(p); k++) exp[int'(t) * 18 + offs(p) + k] = d[k];
        end
    endtask : wr
    // Full reconfiguration, then compare the PLL latches with the expected chain
    task automatic rc(input logic [7:0] dly);
        int n;
        bit ar;
        bit sd;
        bit early;
        int upd;
        old = latch;
        upd = updates;
        done_dly <= dly;
        @(posedge clock);
        reconfig <= 1'b1;
        #1 check(busy, 1'b0);
        @(posedge clock);
        reconfig <= 1'b0;
        #1 check(busy, 1'b1);
        n = 0;
        ar = 0;
        sd = 0;
        early = 0;
        while (busy === 1'b1 && n < 4000) begin
            @(posedge clock);
            #1 sd = sd | (pll_scandone === 1'b1);
            early = early | (pll_areset === 1'b1 && !sd);
            ar = ar | (pll_areset === 1'b1);
            n++;
        end
        check(busy, 1'b0);
        check(updates, upd + 1);
        check(early, 1'b0);
        check(ar, 1'b1);
        check(pll_areset, 1'b0);
        check(latch, exp);
        check(last_bits, 162);
        check(prior_parity, ^old);
    endtask : rc
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    // Watchdog well beyond four reconfigurations
    initial begin
        #300000;
        errors++;
        final_report();
    end
    // Main sequence; strobes are single cycle except the refusal case
    initial begin
        void'($urandom(32'h068B));
        exp = '0;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        repeat (40) @(posedge clock);
        rc(8'h00);
        wr(4'h8, 3'h0, 9'h1FF, 0);
        wr(4'h0, 3'h5, 9'h1FE, 0);
        wr(4'h9, 3'h0, 9'h0FF, 0);
        wr(4'h3, 3'h2, 9'h0FF, 0);
        wr(4'h4, 3'h1, 9'h0A5, 1);
        wr(4'h4, 3'h4, 9'h1FF, 0);
        for (int i = 0; i < 24; i++) wr(4'($urandom % 9), pk[$urandom % 4], 9'($urandom), 0);
        rc(8'h02);
        rc(8'h20);
        wr(4'h2, 3'h4, 9'h001, 0);
        rc(8'h05);
        @(posedge clock);
        pll_areset_in <= 1'b1;
        @(posedge clock);
        #1 check(pll_areset, 1'b1);
        check(busy, 1'b0);
        @(posedge clock);
        pll_areset_in <= 1'b0;
        repeat (6) @(posedge clock);
        #1 check(pll_areset, 1'b0);
        final_report();
    end
endmodule : prc_core_tb

// ===== sim/prc_pll_model.sv
// Behavioural PLL scan chain, configuration latches and scan-done flag
`timescale 1ns/1ps
module prc_pll_model (
    // Scan link from the controller
    input wire logic scan_clock,
    input wire logic scanclkena,
    input wire logic scandata,
    input wire logic configupdate,
    input wire logic areset,
    // Scan-done delay in scan cycles, set per test
    input wire logic [7:0] done_dly,
    // Back to the controller and the bench
    output logic scandataout,
    output logic scandone,
    output logic [161:0] latch,
    output int last_bits,
    output int updates
);
    logic [161:0] sr;
    int nbits;
    logic [7:0] wait_cnt;
    bit pending;
    // Old chain leaves MSB first as the new one enters
    assign scandataout = sr[161];
    initial begin
        sr = '0;
        latch = '0;
        scandone = 1'b0;
        nbits = 0;
        updates = 0;
        last_bits = 0;
        pending = 0;
    end
    // Sample half a period after launch; count bits of one frame
    always @(negedge scan_clock) begin
        if (scanclkena) begin
            sr <= {sr[160:0], scandata};
            nbits <= nbits + 1;
        end else if (!configupdate) begin
            nbits <= 0;
        end
    end
    // Update loads latches; scan-done follows after a chosen delay
    always @(posedge scan_clock or posedge areset) begin
        if (areset) begin
            scandone <= 1'b0; // Only the controller resets this PLL
        end else if (configupdate) begin
            latch <= sr;
            last_bits <= nbits;
            updates <= updates + 1;
            wait_cnt <= done_dly;
            pending <= 1;
        end else if (pending) begin
            if (wait_cnt == 8'h00) begin
                scandone <= 1'b1;
                pending <= 0;
            end else begin
                wait_cnt <= wait_cnt - 8'h01;
            end
        end
    end
endmodule : prc_pll_model
